// ---- core/flag_latch.v ----
`timescale 1ns/1ps

// ********************************************************
// Sticky flags with clear, mask and pending summary
// ********************************************************
module flag_latch #(
    parameter WIDTH = 4
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Flag control
    input wire [WIDTH-1:0] set,
    input wire [WIDTH-1:0] clr,
    input wire [WIDTH-1:0] mask,
    // Flag state
    output reg [WIDTH-1:0] flags,
    output wire [WIDTH-1:0] pending
);

// Set wins over a clear in the same cycle
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        flags <= {WIDTH{1'b0}};
    end else begin
        flags <= (flags & ~clr) | set;
    end
end

// Unmasked flags that may raise the interrupt
assign pending = flags & ~mask;

endmodule // flag_latch

// ---- core/mgmt_defines.vh ----
`ifndef MGMT_DEFINES_VH
`define MGMT_DEFINES_VH

// ********************************************************
// Clock rate
// ********************************************************
`define CLK_MHZ 100

// ********************************************************
// Timing figures and derived cycle counts
// ********************************************************
`define T_INIT_MS 2000
`define T_RESET_MIN_US 2
`define RESET_MIN_CYCLES (`T_RESET_MIN_US * `CLK_MHZ)
`define INIT_CYCLES (`T_INIT_MS * 1000 * `CLK_MHZ)

// ********************************************************
// Two-wire device address (arbitrary value)
// ********************************************************
`define DEV_ADDR 7'h50

// ********************************************************
// Byte offsets of the memory map
// ********************************************************
`define STATUS_ADDR 8'h02
`define FLAG_ADDR 8'h03
`define PDOWN_ADDR 8'h5d
`define MASK_ADDR 8'h64
`define EMPH_HI_ADDR 8'hec
`define EMPH_LO_ADDR 8'hed

// ********************************************************
// Field positions and reset values
// ********************************************************
`define NOT_READY_BIT 0
`define PDOWN_BIT 1
`define FLAG_RX_LOS 0
`define FLAG_TX_FAULT 1
`define FLAG_OTHER 2
`define FLAG_INIT_DONE 3
`define EMPH_RSVD_BIT 3
`define MASK_RESET 4'h0
`define EMPH_RESET 16'h0000

`endif

// ---- core/module_mgmt_status_timing.v ----
// Overview of operation
// (RL1) Emphasis code 0-7 gives 0-7 dB; top bit set is reserved.
// (RL2) Fully functional within 2000 ms of power-on or reset release.
// (RL3) Reset only when reset pin stays low at least 2 us.
// (RL4) Two-wire bus answers within 2000 ms of power-on.
// (RL5) Within 2000 ms clear data-not-ready bit and assert interrupt.
// (RL6) Fully functional within 2000 ms after reset pin rises.
// (RL7) Low-power pin high enters lower power within 100 us.
// (RL8) Interrupt output goes low within 200 ms of a triggering condition.
// (RL9) Flags clear on read; interrupt releases within 500 us.
// (RL10) Loss-of-signal entry sets flag and interrupt within 100 ms.
// (RL11) Transmit fault entry sets flag and interrupt within 200 ms.
// (RL12) Other conditions set their flag and interrupt within 200 ms.
// (RL13) Setting a mask bit blocks its flag within 100 ms.
// (RL14) Clearing a mask bit restores its interrupt within 100 ms.
// (RL15) Bus answers within 100 us after module select goes low.
// (RL16) Bus stops answering within 100 us after module select goes high.
// (RL17) Setting power-down bit enters lower power within 100 ms.
// (RL18) Clearing power-down bit restores full function within 300 ms.
// (RL19) Full function means interrupt raised by data-not-ready clearing.
// (RL20) Write delays count from the falling edge after the stop bit.
`timescale 1ns/1ps
`include "mgmt_defines.vh"

module module_mgmt_status_timing #(
    parameter [31:0] INIT_CYCLES = `INIT_CYCLES
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Control pins from the host
    input wire reset_pin_active_low,
    input wire module_select_pin,
    input wire low_power_pin,
    // Two-wire management bus
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe_n,
    // Interrupt pin
    output reg irq_out_active_low,
    // Internal conditions
    input wire rx_los_state,
    input wire tx_fault_state,
    input wire other_flag_cond,
    // Module state
    output reg module_ready,
    output reg low_power_mode,
    output reg [11:0] rx_emph_db,
    output reg [3:0] rx_emph_enable
);

// ********************************************************
// Constants
// ********************************************************
localparam [31:0] RESET_MIN = `RESET_MIN_CYCLES;

localparam [2:0] S_IDLE = 3'd0;
localparam [2:0] S_ADDR = 3'd1;
localparam [2:0] S_AACK = 3'd2;
localparam [2:0] S_WR = 3'd3;
localparam [2:0] S_WACK = 3'd4;
localparam [2:0] S_RD = 3'd5;
localparam [2:0] S_RACK = 3'd6;

// ********************************************************
// Declarations
// ********************************************************
wire [4:0] pin_level;
wire scl_s;
wire sda_s;
wire rst_pin_s;
wire sel_n_s;
wire lp_s;
reg scl_d;
reg sda_d;
wire scl_rise;
wire scl_fall;
wire bus_start;
wire bus_stop;
reg [31:0] low_cnt;
reg mod_reset;
reg [31:0] init_cnt;
wire bus_en;
reg [3:0] cond_d;
wire [3:0] cond_now;
wire [3:0] flag_set;
reg [3:0] flag_clr;
reg [3:0] rd_clr;
wire [3:0] flags;
wire [3:0] pending;
reg [3:0] mask;
reg pdown;
reg [15:0] emph;
reg [2:0] state;
reg [3:0] bitcnt;
reg [7:0] shift;
reg [7:0] ptr;
reg rw;
reg first_byte;
reg sda_drv;
reg [7:0] rd_data;

// ********************************************************
// Pin synchronisers
// ********************************************************
// Idle levels: bus high, reset high, select high, low-power low
pin_sync #(
    .WIDTH(5),
    .RST_VAL(5'b01111)
) u_pin_sync (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pin({low_power_pin, module_select_pin, reset_pin_active_low, sda_in, scl_in}),
    .level(pin_level)
);

assign scl_s = pin_level[0];
assign sda_s = pin_level[1];
assign rst_pin_s = pin_level[2];
assign sel_n_s = pin_level[3];
assign lp_s = pin_level[4];

// ********************************************************
// Reset pin filter
// ********************************************************
// (RL3) minimum low time
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        low_cnt <= 32'h0000_0000;
        mod_reset <= 1'b0;
    end else if (rst_pin_s) begin
        low_cnt <= 32'h0000_0000;
        mod_reset <= 1'b0;
    end else begin
        if (low_cnt != RESET_MIN) begin
            low_cnt <= low_cnt + 32'h0000_0001;
        end
        if (low_cnt == RESET_MIN - 32'h0000_0001) begin
            mod_reset <= 1'b1;
        end
    end
end

// ********************************************************
// Initialisation timer
// ********************************************************
// (RL2) (RL6) ready after init count
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        init_cnt <= 32'h0000_0000;
        module_ready <= 1'b0;
    end else begin
        if (mod_reset) begin
            init_cnt <= 32'h0000_0000;
            module_ready <= 1'b0;
        end else if (!module_ready) begin
            init_cnt <= init_cnt + 32'h0000_0001;
            if (init_cnt >= INIT_CYCLES - 32'h0000_0001) begin
                module_ready <= 1'b1;
            end
        end
    end
end

// ********************************************************
// Flag events and latches
// ********************************************************
// Current condition levels, init completion on top
assign cond_now = {module_ready, other_flag_cond, tx_fault_state, rx_los_state};

// Previous levels for entry detection
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        cond_d <= 4'h0;
    end else begin
        cond_d <= cond_now;
    end
end

// (RL10) (RL11) (RL12) (RL5) flag on entry
assign flag_set = cond_now & ~cond_d;

flag_latch #(
    .WIDTH(4)
) u_flag_latch (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .set(flag_set),
    .clr(flag_clr),
    .mask(mask),
    .flags(flags),
    .pending(pending)
);

// ********************************************************
// Interrupt and power outputs
// ********************************************************
// (RL8) (RL13) (RL14) (RL19) interrupt from unmasked flags
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        irq_out_active_low <= 1'b1;
    end else begin
        irq_out_active_low <= ~(|pending);
    end
end

// (RL7) (RL17) (RL18) lower power from pin or bit
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        low_power_mode <= 1'b0;
    end else begin
        low_power_mode <= lp_s | pdown;
    end
end

// ********************************************************
// Emphasis decode
// ********************************************************
// (RL1) code to dB, reserved codes give none
genvar lane;
generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_emph
        always @(posedge core_clk or negedge reset_n) begin
            if (!reset_n) begin
                rx_emph_db[3*lane+2:3*lane] <= 3'h0;
                rx_emph_enable[lane] <= 1'b0;
            end else if (emph[4*lane+`EMPH_RSVD_BIT]) begin
                rx_emph_db[3*lane+2:3*lane] <= 3'h0;
                rx_emph_enable[lane] <= 1'b0;
            end else begin
                rx_emph_db[3*lane+2:3*lane] <= emph[4*lane+2:4*lane];
                rx_emph_enable[lane] <= 1'b1;
            end
        end
    end
endgenerate

// ********************************************************
// Two-wire bus edge detection
// ********************************************************
// Delayed copies of the synchronised bus lines
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        scl_d <= 1'b1;
        sda_d <= 1'b1;
    end else begin
        scl_d <= scl_s;
        sda_d <= sda_s;
    end
end

assign scl_rise = scl_s & ~scl_d;
assign scl_fall = ~scl_s & scl_d;
assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

// (RL4) (RL15) (RL16) answer only when selected
assign bus_en = ~sel_n_s & ~mod_reset;

// Open-drain data line, only ever pulled low
assign sda_out = 1'b0;
assign sda_oe_n = ~sda_drv;

// ********************************************************
// Read data mux
// ********************************************************
// (RL5) status byte shows data-not-ready
always @* begin
    rd_data = 8'h00;
    case (ptr)
        `STATUS_ADDR: rd_data[`NOT_READY_BIT] = ~module_ready;
        `FLAG_ADDR: rd_data[3:0] = flags;
        `MASK_ADDR: rd_data[3:0] = mask;
        `PDOWN_ADDR: rd_data[`PDOWN_BIT] = pdown;
        `EMPH_HI_ADDR: rd_data = emph[15:8];
        `EMPH_LO_ADDR: rd_data = emph[7:0];
        default: rd_data = 8'h00;
    endcase
end

// ********************************************************
// Two-wire slave
// ********************************************************
// Transaction state, pointer and writable bytes
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        state <= S_IDLE;
        bitcnt <= 4'h0;
        shift <= 8'h00;
        ptr <= 8'h00;
        rw <= 1'b0;
        first_byte <= 1'b0;
        sda_drv <= 1'b0;
        mask <= `MASK_RESET;
        pdown <= 1'b0;
        emph <= `EMPH_RESET;
        rd_clr <= 4'h0;
        flag_clr <= 4'h0;
    end else begin
        flag_clr <= 4'h0;
        if (mod_reset) begin
            state <= S_IDLE;
            sda_drv <= 1'b0;
            mask <= `MASK_RESET;
            pdown <= 1'b0;
            emph <= `EMPH_RESET;
            rd_clr <= 4'h0;
        end else if (!bus_en || bus_start || bus_stop) begin
            // (RL9) clear flags read in this transaction
            flag_clr <= rd_clr;
            rd_clr <= 4'h0;
            sda_drv <= 1'b0;
            bitcnt <= 4'h0;
            state <= (bus_en && bus_start) ? S_ADDR : S_IDLE;
        end else begin
            case (state)
                S_IDLE: begin
                    sda_drv <= 1'b0;
                end
                S_ADDR: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'h8) begin
                        if (shift[7:1] == `DEV_ADDR) begin
                            sda_drv <= 1'b1;
                            rw <= shift[0];
                            state <= S_AACK;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                end
                S_AACK: begin
                    if (scl_fall) begin
                        if (rw) begin
                            sda_drv <= ~rd_data[7];
                            bitcnt <= 4'h1;
                            state <= S_RD;
                            if (ptr == `FLAG_ADDR) begin
                                rd_clr <= rd_clr | flags;
                            end
                        end else begin
                            sda_drv <= 1'b0;
                            bitcnt <= 4'h0;
                            first_byte <= 1'b1;
                            state <= S_WR;
                        end
                    end
                end
                S_WR: begin
                    if (scl_rise) begin
                        shift <= {shift[6:0], sda_s};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == 4'h8) begin
                        sda_drv <= 1'b1;
                        state <= S_WACK;
                        first_byte <= 1'b0;
                        if (first_byte) begin
                            ptr <= shift;
                        end else begin
                            // (RL20) control writes act at once
                            ptr <= ptr + 8'h01;
                            case (ptr)
                                `MASK_ADDR: mask <= shift[3:0];
                                `PDOWN_ADDR: pdown <= shift[`PDOWN_BIT];
                                `EMPH_HI_ADDR: emph[15:8] <= shift;
                                `EMPH_LO_ADDR: emph[7:0] <= shift;
                                default: ptr <= ptr + 8'h01;
                            endcase
                        end
                    end
                end
                S_WACK: begin
                    if (scl_fall) begin
                        sda_drv <= 1'b0;
                        bitcnt <= 4'h0;
                        state <= S_WR;
                    end
                end
                S_RD: begin
                    if (scl_fall) begin
                        if (bitcnt == 4'h8) begin
                            sda_drv <= 1'b0;
                            state <= S_RACK;
                        end else begin
                            if (bitcnt == 4'h0 && ptr == `FLAG_ADDR) begin
                                rd_clr <= rd_clr | flags;
                            end
                            sda_drv <= ~rd_data[3'd7 - bitcnt[2:0]];
                            bitcnt <= bitcnt + 4'h1;
                        end
                    end
                end
                S_RACK: begin
                    if (scl_rise) begin
                        if (!sda_s) begin
                            ptr <= ptr + 8'h01;
                            bitcnt <= 4'h0;
                            state <= S_RD;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                    sda_drv <= 1'b0;
                end
            endcase
        end
    end
end

endmodule // module_mgmt_status_timing

// ---- core/pin_sync.v ----
`timescale 1ns/1ps

// ********************************************************
// Two-flop synchroniser for pins from outside the clock domain
// ********************************************************
module pin_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Pins in, synchronised levels out
    input wire [WIDTH-1:0] pin,
    output reg [WIDTH-1:0] level
);

reg [WIDTH-1:0] meta;

// First stage feeds only the second stage
always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
        meta <= RST_VAL;
        level <= RST_VAL;
    end else begin
        meta <= pin;
        level <= meta;
    end
end

endmodule // pin_sync

// ---- tb/host_model.sv ----
`timescale 1ns/1ps

// ****************************************
// Host side of the two-wire bus
// ****************************************
module host_model (
    // Clock
    input wire core_clk,
    // Resolved data line
    input wire sda,
    // Lines driven by the host
    output reg scl,
    output reg sda_rel
);
    // Bus idle: clock stands high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // Wait falling edges; four make a quarter of the 160 ns bit
    task w(input integer n);
        repeat (n) @(negedge core_clk);
    endtask
    // Start or repeated start
    task start;
        begin
            sda_rel = 1'b1;
            w(4);
            scl = 1'b1;
            w(4);
            sda_rel = 1'b0;
            w(4);
            scl = 1'b0;
            w(4);
        end
    endtask
    // Stop, then bus idle
    task stop;
        begin
            sda_rel = 1'b0;
            w(4);
            scl = 1'b1;
            w(4);
            sda_rel = 1'b1;
            w(8);
        end
    endtask
    // One bit; data moves only while the clock is low
    task bit_x(input logic b, output logic r);
        begin
            sda_rel = b;
            w(4);
            scl = 1'b1;
            w(4);
            r = sda;
            w(4);
            scl = 1'b0;
            w(4);
        end
    endtask
    // Eight bits MSB first, then the acknowledge bit
    task xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ak);
        integer i;
        begin
            for (i = 7; i >= 0; i--) bit_x(d[i], q[i]);
            bit_x(ai, ak);
        end
    endtask
endmodule // host_model

// ---- tb/module_mgmt_status_timing_sva.sv ----
`timescale 1ns/1ps

// ****************************************
// Port checker for the management block
// ****************************************
module mgmt_checker #(
    parameter [31:0] INIT_CYCLES = 32'h32
) (
    // Clock and reset
    input wire core_clk,
    input wire reset_n,
    // Pins and bus
    input wire reset_pin_active_low,
    input wire module_select_pin,
    input wire low_power_pin,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe_n,
    input wire irq_out_active_low,
    // Conditions and state
    input wire rx_los_state,
    input wire tx_fault_state,
    input wire other_flag_cond,
    input wire module_ready,
    input wire low_power_mode,
    input wire [11:0] rx_emph_db,
    input wire [3:0] rx_emph_enable
);
    reg [9:0] low_cnt;
    reg [31:0] nr_cnt;
    wire [11:0] en_bits = {{3{rx_emph_enable[3]}}, {3{rx_emph_enable[2]}},
        {3{rx_emph_enable[1]}}, {3{rx_emph_enable[0]}}};
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // Length of reset pin pulse and of time spent not ready
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt <= 10'h000;
            nr_cnt <= 32'h0;
        end else begin
            low_cnt <= reset_pin_active_low ? 10'h000 : low_cnt + {9'h000, low_cnt != 10'h3ff};
            nr_cnt <= (module_ready || !reset_pin_active_low || low_power_mode) ? 32'h0
                : nr_cnt + 32'h1;
        end
    end
    a_emph_reserved_zero: assert property (
        (rx_emph_db & ~en_bits) == 12'h000) else $error("reserved lane has nonzero dB");
    a_init_bound: assert property (
        nr_cnt <= INIT_CYCLES + 32'h14) else $error("not ready for too long");
    a_short_pulse_ignored: assert property (
        low_cnt inside {[10'h001:10'h096]} && module_ready |=> module_ready)
        else $error("short reset pulse dropped ready");
    a_long_pulse_resets: assert property (
        low_cnt == 10'h104 |-> !module_ready) else $error("long reset pulse ignored");
    a_ready_raises_irq: assert property (
        $rose(module_ready) |-> ##[1:3] !irq_out_active_low) else $error("no irq at ready");
    a_lowpin_enters_low: assert property (
        $rose(low_power_pin) |-> ##[1:10] low_power_mode) else $error("low power pin late");
    a_deselect_releases: assert property (
        module_select_pin [*8] |-> sda_oe_n) else $error("bus driven while deselected");
    a_drive_needs_select: assert property (
        !sda_oe_n |-> !$past(module_select_pin, 5)) else $error("drive without select");
    a_data_moves_scl_low: assert property (
        (!module_select_pin) [*5] ##0 $changed(sda_oe_n) |-> !scl_in)
        else $error("data changed while clock high");
    c_ready: cover property ($rose(module_ready));
    c_irq: cover property ($fell(irq_out_active_low));
    c_ack: cover property (!sda_oe_n);
    c_low_power: cover property ($rose(low_power_mode));
endmodule // mgmt_checker

bind module_mgmt_status_timing mgmt_checker #(.INIT_CYCLES(INIT_CYCLES)) u_chk (
    .core_clk(core_clk), .reset_n(reset_n), .reset_pin_active_low(reset_pin_active_low),
    .module_select_pin(module_select_pin), .low_power_pin(low_power_pin), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .irq_out_active_low(irq_out_active_low), .rx_los_state(rx_los_state),
    .tx_fault_state(tx_fault_state), .other_flag_cond(other_flag_cond),
    .module_ready(module_ready), .low_power_mode(low_power_mode),
    .rx_emph_db(rx_emph_db), .rx_emph_enable(rx_emph_enable));

// ---- tb/test_module_mgmt_status_timing.sv ----
`timescale 1ns/1ps

// ****************************************
// Bench for the management block
// ****************************************
module test_module_mgmt_status_timing;
    localparam [31:0] INIT = 32'h32;
    logic core_clk;
    logic reset_n;
    logic rpin;
    logic sel;
    logic lp;
    logic [2:0] cond;
    logic [7:0] q;
    logic k;
    integer fails = 0;
    integer comparisons = 0;
    integer c;
    wire scl, host_sda, sda_out, sda_oe_n, irq_out_active_low, module_ready, low_power_mode;
    wire [11:0] rx_emph_db;
    wire [3:0] rx_emph_enable;
    wire sda = host_sda & (sda_oe_n | sda_out);
    // Design and host
    module_mgmt_status_timing #(.INIT_CYCLES(INIT)) dut (.core_clk(core_clk),
        .reset_n(reset_n), .reset_pin_active_low(rpin), .module_select_pin(sel),
        .low_power_pin(lp), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .irq_out_active_low(irq_out_active_low),
        .rx_los_state(cond[0]), .tx_fault_state(cond[1]), .other_flag_cond(cond[2]),
        .module_ready(module_ready), .low_power_mode(low_power_mode),
        .rx_emph_db(rx_emph_db), .rx_emph_enable(rx_emph_enable));
    host_model host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_rel(host_sda));
    // 100 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task report_and_stop;
        begin
            $display("fails=%0d comparisons=%0d", fails, comparisons);
            if (fails == 0 && comparisons > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e, input string m);
        begin
            comparisons++;
            if (g !== e) begin
                fails++;
                $display("BAD %0t %s got %h exp %h", $time, m, g, e);
            end
        end
    endtask
    function logic sig(input integer s);
        sig = (s == 0) ? module_ready : (s == 1) ? irq_out_active_low : low_power_mode;
    endfunction
    // Bounded wait for an output level
    task wt(input integer s, input logic v, input integer n);
        integer i;
        begin
            i = 0;
            while (sig(s) !== v && i < n) begin
                @(negedge core_clk);
                i++;
            end
            chk(sig(s), v, "wait level");
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        begin
            host.start;
            host.xfer(8'ha0, 1'b1, q, k);
            chk(k, 1'b0, "addr ack");
            host.xfer(a, 1'b1, q, k);
            host.xfer(d, 1'b1, q, k);
            chk(k, 1'b0, "data ack");
            host.stop;
        end
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        begin
            host.start;
            host.xfer(8'ha0, 1'b1, q, k);
            host.xfer(a, 1'b1, q, k);
            host.start;
            host.xfer(8'ha1, 1'b1, q, k);
            host.xfer(8'hff, 1'b1, q, k);
            host.stop;
            chk(q, e, "read byte");
        end
    endtask
    // Address probe, returns acknowledge in k
    task probe;
        begin
            host.start;
            host.xfer(8'ha0, 1'b1, q, k);
            host.stop;
        end
    endtask
    // Watchdog, about twice the expected length of the run
    initial begin
        #600000;
        fails++;
        report_and_stop;
    end
    // Test sequence
    initial begin
        reset_n = 1'b0;
        rpin = 1'b1;
        sel = 1'b0;
        lp = 1'b0;
        cond = 3'h0;
        host.w(12);
        reset_n = 1'b1;
        wt(0, 1'b1, INIT + 20);
        wt(1, 1'b0, 10);
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h08);
        wt(1, 1'b1, 50);
        rd(8'h03, 8'h00);
        for (c = 0; c < 3; c++) begin
            cond = 3'h1 << c;
            wt(1, 1'b0, 10);
            rd(8'h03, 8'h01 << c);
            wt(1, 1'b1, 50);
            cond = 3'h0;
        end
        wr(8'h64, 8'h01);
        cond = 3'h1;
        host.w(20);
        chk(irq_out_active_low, 1'b1, "masked irq");
        wr(8'h64, 8'h00);
        wt(1, 1'b0, 20);
        rd(8'h03, 8'h01);
        cond = 3'h0;
        wt(1, 1'b1, 50);
        for (c = 0; c < 16; c++) begin
            wr(8'hec, {c[3:0], c[3:0]});
            wr(8'hed, {c[3:0], c[3:0]});
            host.w(4);
            chk(rx_emph_db, c[3] ? 12'h000 : {4{c[2:0]}}, "emph dB");
            chk(rx_emph_enable, c[3] ? 4'h0 : 4'hf, "emph enable");
            rd(8'hec, {c[3:0], c[3:0]});
        end
        rd(8'h80, 8'h00);
        wr(8'h5d, 8'h02);
        wt(2, 1'b1, 10);
        wr(8'h5d, 8'h00);
        wt(2, 1'b0, 10);
        wt(0, 1'b1, INIT + 20);
        lp = 1'b1;
        wt(2, 1'b1, 20);
        lp = 1'b0;
        wt(2, 1'b0, 20);
        sel = 1'b1;
        host.w(10);
        probe;
        chk(k, 1'b1, "deselected ack");
        sel = 1'b0;
        host.w(10);
        probe;
        chk(k, 1'b0, "selected ack");
        rpin = 1'b0;
        host.w(100);
        rpin = 1'b1;
        host.w(10);
        chk(module_ready, 1'b1, "short pulse");
        rd(8'h03, 8'h00);
        wr(8'h64, 8'h0f);
        rpin = 1'b0;
        host.w(260);
        chk(module_ready, 1'b0, "long pulse");
        rpin = 1'b1;
        wt(0, 1'b1, INIT + 20);
        wt(1, 1'b0, 10);
        rd(8'hec, 8'h00);
        report_and_stop;
    end
endmodule // test_module_mgmt_status_timing
